// ===== hdl/bmcrp_pkg.sv
package bmcrp_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_KBASE = 4'h1;
  localparam logic [3:0] REG_UBASE = 4'h2;
  localparam logic [3:0] REG_RAMSZ = 4'h4;

  // Alias selector in address bits 3:2: base, clear, set, invert
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLR = 2'h1,
    OP_SET = 2'h2,
    OP_INV = 2'h3
  } bmcrp_op_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field layout of the matrix configuration register
  localparam logic [31:0] CFG_MASK = 32'h001F0047;
  localparam logic [31:0] CFG_RESET = 32'h001F0041;
  localparam int ERR_LSB = 16;
  localparam int WS_BIT = 6;
  localparam int ARB_LSB = 0;
  localparam int ARB_W = 3;

  // Partition base registers move in 1 KB steps
  localparam logic [31:0] BASE_MASK = 32'h0000FC00;
  localparam logic [31:0] BASE_RESET = 32'h00000000;
  localparam int BASE_W = 16;

  typedef enum logic [2:0] {
    ARB_MODE0 = 3'h0,
    ARB_MODE1 = 3'h1,
    ARB_MODE2 = 3'h2
  } bmcrp_arb_t;

  // Master index equals error-enable bit minus ERR_LSB
  localparam int NUM_MASTERS = 5;
  localparam int M_CPUI = 0;
  localparam int M_CPUD = 1;
  localparam int M_DMA = 2;
  localparam int M_DBG = 3;
  localparam int M_SHARED = 4;

  // Physical target windows; fixed, except the RAM size, which is a default that the RAM_SIZE parameter overrides
  localparam logic [31:0] RAM_BASE = 32'h00000000;
  localparam logic [31:0] RAM_SIZE_DEF = 32'h00010000;
  localparam logic [31:0] FLASH_BASE = 32'h1D000000;
  localparam logic [31:0] FLASH_SIZE = 32'h00040000;
  localparam logic [31:0] PERIPH_BASE = 32'h1F800000;
  localparam logic [31:0] PERIPH_SIZE = 32'h00100000;
  localparam logic [31:0] BOOT_BASE = 32'h1FC00000;
  localparam logic [31:0] BOOT_SIZE = 32'h00000C00;

  function automatic logic bmcrp_in_win(logic [31:0] a, logic [31:0] b,
                                        logic [31:0] sz);
    logic [31:0] off;
    off = a - b;
    return (a >= b) && (off < sz);
  endfunction

  function automatic logic bmcrp_is_mapped(logic [31:0] a,
                                           logic [31:0] ramSz);
    return bmcrp_in_win(a, RAM_BASE, ramSz) ||
           bmcrp_in_win(a, FLASH_BASE, FLASH_SIZE) ||
           bmcrp_in_win(a, PERIPH_BASE, PERIPH_SIZE) ||
           bmcrp_in_win(a, BOOT_BASE, BOOT_SIZE);
  endfunction

endpackage

// ===== hdl/bmcrp_err_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bmcrp_err_if;
  import bmcrp_pkg::*;
  logic [NUM_MASTERS-1:0] errEnable;
  logic debugMode;
  logic [31:0] ramSize;
  logic [NUM_MASTERS-1:0] req;
  logic [NUM_MASTERS-1:0][31:0] addr;
  logic [NUM_MASTERS-1:0] busErr;

  modport cfg (
    output errEnable, debugMode, ramSize, req, addr,
    input busErr
  );
  modport gate (
    input errEnable, debugMode, ramSize, req, addr,
    output busErr
  );
endinterface
`default_nettype wire

// ===== hdl/bmcrp_err_gate.sv
`timescale 1ns/100ps
`default_nettype none
module bmcrp_err_gate (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enables and requests from the configuration side
  bmcrp_err_if.gate eb
);
  import bmcrp_pkg::*;

  logic [NUM_MASTERS-1:0] unmapped;
  logic [NUM_MASTERS-1:0] errAllowed;
  logic [NUM_MASTERS-1:0] busErr_r;

  generate
    for (genvar i = 0; i < NUM_MASTERS; i++) begin : g_master
      assign unmapped[i] = eb.req[i] &&
                           !bmcrp_is_mapped(eb.addr[i], eb.ramSize);
      // CPU enables are ignored in debug mode so a halted core never traps
      if (i == M_CPUI || i == M_CPUD) begin : g_cpu
        assign errAllowed[i] = eb.errEnable[i] && !eb.debugMode;
      end else begin : g_other
        assign errAllowed[i] = eb.errEnable[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busErr_r <= '0;
    end else begin
      busErr_r <= unmapped & errAllowed;
    end
  end

  assign eb.busErr = busErr_r;

  property p_err_shared;
    @(posedge clk) disable iff (!rst_n)
    unmapped[M_SHARED] |=> busErr_r[M_SHARED] == $past(eb.errEnable[M_SHARED]);
  endproperty
  a_err_shared: assert property (p_err_shared)
    else $error("shared bus error does not follow its enable");

  property p_err_debug;
    @(posedge clk) disable iff (!rst_n)
    unmapped[M_DBG] && eb.errEnable[M_DBG] |=> busErr_r[M_DBG];
  endproperty
  a_err_debug: assert property (p_err_debug)
    else $error("debug unit error missing");

  property p_err_dma;
    @(posedge clk) disable iff (!rst_n)
    !eb.errEnable[M_DMA] |=> !busErr_r[M_DMA];
  endproperty
  a_err_dma: assert property (p_err_dma)
    else $error("dma error raised while disabled");

  property p_err_cpud;
    @(posedge clk) disable iff (!rst_n)
    unmapped[M_CPUD] && eb.errEnable[M_CPUD] |=>
      busErr_r[M_CPUD] == !$past(eb.debugMode);
  endproperty
  a_err_cpud: assert property (p_err_cpud)
    else $error("cpu data error wrong for debug state");

  property p_err_cpui;
    @(posedge clk) disable iff (!rst_n)
    eb.debugMode |=> !busErr_r[M_CPUI];
  endproperty
  a_err_cpui: assert property (p_err_cpui)
    else $error("cpu fetch error raised in debug mode");

  property p_mapped_quiet;
    @(posedge clk) disable iff (!rst_n)
    busErr_r != '0 |-> ($past(unmapped) & busErr_r) == busErr_r;
  endproperty
  a_mapped_quiet: assert property (p_mapped_quiet)
    else $error("bus error without an unmapped request");
endmodule
`default_nettype wire

// ===== hdl/bmcrp_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bmcrp_top #(
  parameter logic [31:0] RAM_SIZE = bmcrp_pkg::RAM_SIZE_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [bmcrp_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [bmcrp_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Bus master requests
  input wire logic [bmcrp_pkg::NUM_MASTERS-1:0] masterReq,
  input wire logic [bmcrp_pkg::NUM_MASTERS-1:0][31:0] masterAddr,
  input wire logic debugMode,
  // Matrix controls
  output logic [bmcrp_pkg::NUM_MASTERS-1:0] busErr,
  output logic ramWaitState,
  output logic [bmcrp_pkg::ARB_W-1:0] arbMode,
  output logic [bmcrp_pkg::BASE_W-1:0] kernelProgBase,
  output logic [bmcrp_pkg::BASE_W-1:0] userDataBase
);
  import bmcrp_pkg::*;

  // Byte lanes gate every alias, so a partial write touches only its lanes
  function automatic logic [31:0] apply_op(logic [31:0] old,
                                           logic [31:0] data,
                                           logic [3:0] strb,
                                           logic [1:0] op,
                                           logic [31:0] mask);
    logic [31:0] lanes;
    logic [31:0] d;
    logic [31:0] res;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    d = data & lanes;
    case (op)
      OP_CLR: res = old & ~d;
      OP_SET: res = old | d;
      OP_INV: res = old ^ d;
      default: res = (old & ~lanes) | d;
    endcase
    return res & mask;
  endfunction

  logic [31:0] cfg_r;
  logic [31:0] kBase_r;
  logic [31:0] uBase_r;
  logic [31:0] cfg_nxt;
  logic [31:0] kBase_nxt;
  logic [31:0] uBase_nxt;

  logic awHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic bootSeen_r;

  // Write channel join: address and data may arrive in either order
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire haveAw = awHeld_r || awTake;
  wire haveW = wHeld_r || wTake;
  wire wrFire = haveAw && haveW && !bvalid_r;
  wire [ADDR_W-1:0] curAwAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  wire [31:0] curWData = wHeld_r ? wData_r : s_axi_wdata;
  wire [3:0] curWStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  wire [3:0] wrReg = curAwAddr[7:4];
  wire [1:0] wrOp = curAwAddr[3:2];

  wire wrCfg = wrFire && (wrReg == REG_CFG);
  wire wrKBase = wrFire && (wrReg == REG_KBASE);
  wire wrUBase = wrFire && (wrReg == REG_UBASE);
  wire wrRamSz = (wrReg == REG_RAMSZ) && (wrOp == OP_WRITE);
  wire wrOk = (wrReg == REG_CFG) || (wrReg == REG_KBASE) ||
              (wrReg == REG_UBASE) || wrRamSz;

  assign cfg_nxt = wrCfg ?
    apply_op(cfg_r, curWData, curWStrb, wrOp, CFG_MASK) : cfg_r;
  assign kBase_nxt = wrKBase ?
    apply_op(kBase_r, curWData, curWStrb, wrOp, BASE_MASK) : kBase_r;
  assign uBase_nxt = wrUBase ?
    apply_op(uBase_r, curWData, curWStrb, wrOp, BASE_MASK) : uBase_r;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
      kBase_r <= BASE_RESET;
      uBase_r <= BASE_RESET;
      bootSeen_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      kBase_r <= kBase_nxt;
      uBase_r <= uBase_nxt;
      bootSeen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_r <= 1'b1;
          awAddr_r <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld_r <= 1'b1;
          wData_r <= s_axi_wdata;
          wStrb_r <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // Read path: aliases read back their base register, except the RAM size aliases, which read zero with SLVERR
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [3:0] rdReg = s_axi_araddr[7:4];
  wire [1:0] rdOp = s_axi_araddr[3:2];
  wire rdRamSz = (rdReg == REG_RAMSZ) && (rdOp == OP_WRITE);
  wire rdOk = (rdReg == REG_CFG) || (rdReg == REG_KBASE) ||
              (rdReg == REG_UBASE) || rdRamSz;
  wire [31:0] rdMux = (rdReg == REG_CFG) ? cfg_r :
                      (rdReg == REG_KBASE) ? kBase_r :
                      (rdReg == REG_UBASE) ? uBase_r :
                      rdRamSz ? RAM_SIZE : 32'h00000000;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (arTake) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdMux;
      rresp_r <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Controls toward the matrix
  assign ramWaitState = cfg_r[WS_BIT];
  assign arbMode = cfg_r[ARB_LSB +: ARB_W];
  assign kernelProgBase = kBase_r[BASE_W-1:0];
  assign userDataBase = uBase_r[BASE_W-1:0];

  bmcrp_err_if errBus ();

  assign errBus.errEnable = cfg_r[ERR_LSB +: NUM_MASTERS];
  assign errBus.debugMode = debugMode;
  assign errBus.ramSize = RAM_SIZE;
  assign errBus.req = masterReq;
  assign errBus.addr = masterAddr;
  assign busErr = errBus.busErr;

  bmcrp_err_gate bmcrp_err_gate_inst (
    .clk(clk),
    .rst_n(rst_n),
    .eb(errBus.gate)
  );

  wire [31:0] laneMask = {{8{curWStrb[3]}}, {8{curWStrb[2]}},
                          {8{curWStrb[1]}}, {8{curWStrb[0]}}};

  property p_set_alias;
    @(posedge clk) disable iff (!rst_n)
    wrCfg && (wrOp == OP_SET) |=>
      cfg_r == (($past(cfg_r) | ($past(curWData) & $past(laneMask)))
                & CFG_MASK);
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("set alias did not OR into configuration");

  property p_clr_alias;
    @(posedge clk) disable iff (!rst_n)
    wrKBase && (wrOp == OP_CLR) |=>
      kBase_r == ($past(kBase_r) & ~($past(curWData) & $past(laneMask)));
  endproperty
  a_clr_alias: assert property (p_clr_alias)
    else $error("clear alias wrong on kernel base");

  property p_ws_write;
    @(posedge clk) disable iff (!rst_n)
    wrCfg && (wrOp == OP_WRITE) && curWStrb[0] |=>
      ramWaitState == $past(curWData[WS_BIT]);
  endproperty
  a_ws_write: assert property (p_ws_write)
    else $error("wait state select not updated");

  property p_arb_write;
    @(posedge clk) disable iff (!rst_n)
    wrCfg && (wrOp == OP_WRITE) && curWStrb[0] |=>
      arbMode == $past(curWData[ARB_W-1:0]);
  endproperty
  a_arb_write: assert property (p_arb_write)
    else $error("arbitration field not updated");

  property p_cfg_reserved;
    @(posedge clk) disable iff (!rst_n)
    arTake && (rdReg == REG_CFG) |=> (s_axi_rdata & ~CFG_MASK) == 32'h00000000;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("unimplemented configuration bit read nonzero");

  property p_kbase_write;
    @(posedge clk) disable iff (!rst_n)
    wrKBase && (wrOp == OP_WRITE) && (curWStrb == 4'hF) |=>
      kBase_r == ($past(curWData) & BASE_MASK);
  endproperty
  a_kbase_write: assert property (p_kbase_write)
    else $error("kernel base write lost");

  property p_base_low;
    @(posedge clk) disable iff (!rst_n)
    arTake && ((rdReg == REG_KBASE) || (rdReg == REG_UBASE)) |=>
      s_axi_rdata[9:0] == 10'h000;
  endproperty
  a_base_low: assert property (p_base_low)
    else $error("partition base low bits nonzero");

  property p_reset_kbase;
    @(posedge clk) disable iff (!rst_n)
    !bootSeen_r |-> (kernelProgBase == 16'h0000) && (cfg_r == CFG_RESET);
  endproperty
  a_reset_kbase: assert property (p_reset_kbase)
    else $error("registers not at reset value after reset");

  property p_ubase_shape;
    @(posedge clk) disable iff (!rst_n)
    wrUBase |=> (uBase_r & ~BASE_MASK) == 32'h00000000;
  endproperty
  a_ubase_shape: assert property (p_ubase_shape)
    else $error("user base holds bits outside 15:10");
endmodule
`default_nettype wire

// ===== test/bmcrp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module bmcrp_master_model (
  // Clock
  input wire logic clk,
  // Requests towards the matrix
  output logic [bmcrp_pkg::NUM_MASTERS-1:0] masterReq,
  output logic [bmcrp_pkg::NUM_MASTERS-1:0][31:0] masterAddr
);
  import bmcrp_pkg::*;

  initial begin
    masterReq = '0;
    masterAddr = '0;
  end

  // One request cycle; returns once the answer cycle has settled
  task issue(input int idx, input logic [31:0] a);
    @(posedge clk);
    masterReq[idx] <= 1'b1;
    masterAddr[idx] <= a;
    @(posedge clk);
    masterReq[idx] <= 1'b0;
    // Released address shows junk so a stale value cannot pass
    masterAddr[idx] <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== test/test_bus_matrix_config_ram_partition.sv
`timescale 1ns/100ps
`default_nettype none
module test_bus_matrix_config_ram_partition;
  import bmcrp_pkg::*;
  logic clk, rst_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_MASTERS-1:0] masterReq, busErr;
  logic [NUM_MASTERS-1:0][31:0] masterAddr;
  logic debugMode, ramWaitState;
  logic [ARB_W-1:0] arbMode;
  logic [BASE_W-1:0] kernelProgBase, userDataBase;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rd, ex;

  bmcrp_top bmcrp_top_inst (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .masterReq(masterReq), .masterAddr(masterAddr),
    .debugMode(debugMode), .busErr(busErr),
    .ramWaitState(ramWaitState), .arbMode(arbMode),
    .kernelProgBase(kernelProgBase), .userDataBase(userDataBase)
  );
  bmcrp_master_model bmcrp_master_model_inst (
    .clk(clk),
    .masterReq(masterReq),
    .masterAddr(masterAddr)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic endt(input string nm);
    $display("Test %s done", nm);
  endtask

  // Ready is looked at on the falling edge, where it equals its sampled value
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clk);
      aw = aw || (s_axi_awvalid && s_axi_awready);
      w = w || (s_axi_wvalid && s_axi_wready);
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
    rdr(a);
    chk(nm, rd, exp);
  endtask

  task automatic final_report;
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #50000;
    miscompares++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, debugMode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h001F0041, "cfg");
    rchk(8'h10, 32'h00000000, "kbase");
    rchk(8'h20, 32'h00000000, "ubase");
    rchk(8'h40, 32'h00010000, "ramsz");
    chk("ws", ramWaitState, 1'b1);
    chk("arb", arbMode, 3'h1);
    endt("reset");
    for (int c = 0; c < 3; c++) begin
      wr(8'h00, 32'hFFFFFFB8 | 32'(c));
      rchk(8'h00, 32'h001F0000 | 32'(c), "cfg");
      chk("arb", arbMode, 3'(c));
      chk("ws", ramWaitState, 1'b0);
    end
    endt("config");
    wr(8'h10, 32'hFFFFFFFF);
    rchk(8'h10, 32'h0000FC00, "kbase");
    wr(8'h10, 32'h000008FF);
    rchk(8'h10, 32'h00000800, "kbase");
    wr(8'h20, 32'hFFFFFFFF);
    rchk(8'h20, 32'h0000FC00, "ubase");
    chk("kout", kernelProgBase, 16'h0800);
    chk("uout", userDataBase, 16'hFC00);
    endt("bases");
    wr(8'h00, 32'h00000001);
    wr(8'h08, 32'h00140040);
    rchk(8'h00, 32'h00140041, "set");
    chk("ws", ramWaitState, 1'b1);
    wr(8'h04, 32'h00040001);
    rchk(8'h0C, 32'h00100040, "clr");
    wr(8'h0C, 32'h000F0002);
    rchk(8'h00, 32'h001F0042, "inv");
    wr(8'h1C, 32'h00001C00);
    rchk(8'h10, 32'h00001400, "kinv");
    wr(8'h14, 32'h00000400);
    rchk(8'h10, 32'h00001000, "kclr");
    // Only the low lane is enabled, so the writable bits must not move
    s_axi_wstrb <= 4'h1;
    wr(8'h10, 32'h0000FC00);
    s_axi_wstrb <= 4'hF;
    rchk(8'h10, 32'h00001000, "lanes");
    endt("aliases");
    wr(8'h30, 32'hFFFFFFFF, RESP_SLVERR);
    rdr(8'h30, RESP_SLVERR);
    chk("unmapped", rd, 32'h0);
    endt("unmapped");
    // Pass 5 enables nothing; RAM end is the mapped boundary
    for (int e = 0; e < 6; e++) begin
      wr(8'h00, 32'h00000041 | (32'h1 << (16 + e)));
      for (int m = 0; m < NUM_MASTERS; m++) begin
        bmcrp_master_model_inst.issue(m, 32'h00010000);
        ex = (e == m) ? (32'h1 << m) : 32'h0;
        chk("busErr", busErr, ex);
        bmcrp_master_model_inst.issue(m, 32'h0000FFFC);
        chk("busErr", busErr, 32'h0);
      end
    end
    wr(8'h00, 32'h001F0041);
    debugMode <= 1'b1;
    for (int m = 0; m < NUM_MASTERS; m++) begin
      bmcrp_master_model_inst.issue(m, 32'h30000000);
      chk("dbgErr", busErr, (m < 2) ? 32'h0 : (32'h1 << m));
    end
    debugMode <= 1'b0;
    endt("errors");
    // Leave the configuration away from its reset value before resetting
    wr(8'h00, 32'h00000002);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h10, 32'h00000000, "kbase");
    rchk(8'h00, 32'h001F0041, "cfg");
    rchk(8'h20, 32'h00000000, "ubase");
    endt("rereset");
    final_report();
  end
endmodule
`default_nettype wire
